// File: common/cssc_pkg.sv
// package for the clock source and start-up control block
// assumes fuse values arrive as static levels and the watchdog oscillator tick as a one-cycle pulse
package cssc_pkg;
  // ==========================================
  // source kinds
  typedef enum logic [4:0] {
    SRC_XTAL = 5'h01,
    SRC_LFXT = 5'h02,
    SRC_ERC = 5'h04,
    SRC_IRC = 5'h08,
    SRC_EXT = 5'h10
  } cssc_src_t;
  // ==========================================
  // controller states
  typedef enum logic [4:0] {
    ST_RESET_DLY = 5'h01,
    ST_SRC_START = 5'h02,
    ST_RUN = 5'h04,
    ST_SLEEP = 5'h08,
    ST_FAULT = 5'h10
  } cssc_state_t;
  // ==========================================
  // sleep modes
  localparam logic [2:0] SLP_IDLE = 3'h0;
  localparam logic [2:0] SLP_ADC_NR = 3'h1;
  localparam logic [2:0] SLP_PDOWN = 3'h2;
  localparam logic [2:0] SLP_PSAVE = 3'h3;
  localparam logic [2:0] SLP_STANDBY = 3'h6;
  localparam logic [2:0] SLP_EXT_STANDBY = 3'h7;
  // ==========================================
  // fuse layout and delivered defaults
  localparam logic FUSE_PROGRAMMED = 1'h0;
  localparam logic [3:0] DEF_SRC_SEL = 4'h1;
  localparam logic [1:0] DEF_SUT_SEL = 2'h2;
  localparam logic [3:0] SEL_XTAL_LO = 4'hA;
  localparam logic [3:0] SEL_LFXT = 4'h9;
  localparam logic [3:0] SEL_ERC_LO = 4'h5;
  localparam logic [3:0] SEL_IRC_LO = 4'h1;
  localparam logic [3:0] SEL_EXT = 4'h0;
  localparam logic [2:0] XTAL_MODE_LO = 3'h5;
  localparam logic [2:0] XTAL_MODE_MID = 3'h6;
  localparam logic [2:0] XTAL_MODE_HI = 3'h7;
  // ==========================================
  // start-up counts in source cycles
  localparam logic [15:0] CK_6 = 16'h0006;
  localparam logic [15:0] CK_18 = 16'h0012;
  localparam logic [15:0] CK_258 = 16'h0102;
  localparam logic [15:0] CK_1K = 16'h0400;
  localparam logic [15:0] CK_16K = 16'h4000;
  localparam logic [15:0] CK_32K = 16'h8000;
  // reset delays in watchdog oscillator cycles
  localparam int WDT_SHORT_CYCLES = 4096;
  localparam int WDT_LONG_CYCLES = 65536;
  localparam logic [1:0] DLY_NONE = 2'h0;
  localparam logic [1:0] DLY_SHORT = 2'h1;
  localparam logic [1:0] DLY_LONG = 2'h2;
endpackage

// File: verilog/cssc_top.sv
// clock source selection, start-up timing and clock-domain gating
// assumes CLOCK is the selected source clock and WDT_TICK pulses once per watchdog oscillator cycle
//
// Overview of operation
// - decode four-bit source select into five kinds
// - fuse one means unprogrammed, zero programmed
// - count source cycles after power-down/save wake
// - reset adds none, 4K or 64K watchdog cycles
// - default fuses select internal RC, longest delay
// - crystal upper three bits pick oscillator mode
// - crystal low bit plus start-up bits: wake count
// - crystal low bit plus start-up bits: reset delay
// - low-frequency crystal only for code 1001
// - low-frequency start-up table, code 11 reserved
// - gate unused clock domains by sleep mode
// - core clock stop halts all core work
// - flash clock follows core clock
// - async interrupt and address logic always enabled
// - async timer domain runs during sleep except power-down and standby
// - converter domain runs while core, peripheral halted
`timescale 1ns/1ps
module cssc_top #(
  parameter int WDT_SHORT = cssc_pkg::WDT_SHORT_CYCLES,
  parameter int WDT_LONG = cssc_pkg::WDT_LONG_CYCLES
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic FUSES_VALID,
  input wire logic [3:0] CLOCK_SOURCE_SELECT,
  input wire logic [1:0] STARTUP_TIME_SELECT,
  input wire logic OSCILLATOR_OPTION,
  input wire logic WDT_TICK,
  input wire logic SLEEP_REQ,
  input wire logic [2:0] SLEEP_MODE,
  input wire logic WAKE_REQ,
  output logic CORE_CLOCK_EN,
  output logic FLASH_CLOCK_EN,
  output logic PERIPHERAL_CLOCK_EN,
  output logic ASYNC_TIMER_CLOCK_EN,
  output logic CONVERTER_CLOCK_EN,
  output logic ASYNC_WAKE_LOGIC_EN,
  output logic EXEC_READY,
  output logic [4:0] SOURCE_KIND,
  output logic [1:0] XTAL_MODE,
  output logic FULL_SWING,
  output logic CONFIG_ERROR
);
  // ==========================================
  // decode functions
  function automatic cssc_pkg::cssc_src_t decode_src(input logic [3:0] sel);
    cssc_pkg::cssc_src_t k;
    if (sel >= cssc_pkg::SEL_XTAL_LO) begin
      k = cssc_pkg::SRC_XTAL;
    end else if (sel == cssc_pkg::SEL_LFXT) begin
      k = cssc_pkg::SRC_LFXT;
    end else if (sel >= cssc_pkg::SEL_ERC_LO) begin
      k = cssc_pkg::SRC_ERC;
    end else if (sel >= cssc_pkg::SEL_IRC_LO) begin
      k = cssc_pkg::SRC_IRC;
    end else begin
      k = cssc_pkg::SRC_EXT;
    end
    return k;
  endfunction

  // wake count in source cycles; bit 16 flags a reserved code
  function automatic logic [16:0] wake_count(input cssc_pkg::cssc_src_t k, input logic lo, input logic [1:0] startup_time_select);
    logic [16:0] c;
    c = {1'h0, cssc_pkg::CK_6};
    case (k)
      cssc_pkg::SRC_XTAL: begin
        case ({lo, startup_time_select})
          3'h0, 3'h1: c = {1'h0, cssc_pkg::CK_258};
          3'h2, 3'h3, 3'h4: c = {1'h0, cssc_pkg::CK_1K};
          default: c = {1'h0, cssc_pkg::CK_16K};
        endcase
      end
      cssc_pkg::SRC_LFXT: begin
        case (startup_time_select)
          2'h0, 2'h1: c = {1'h0, cssc_pkg::CK_1K};
          2'h2: c = {1'h0, cssc_pkg::CK_32K};
          default: c = {1'h1, cssc_pkg::CK_6};
        endcase
      end
      cssc_pkg::SRC_ERC: begin
        c = (startup_time_select == 2'h3) ? {1'h0, cssc_pkg::CK_6} : {1'h0, cssc_pkg::CK_18};
      end
      default: begin
        c = {(startup_time_select == 2'h3), cssc_pkg::CK_6};
      end
    endcase
    return c;
  endfunction

  // reset delay class
  function automatic logic [1:0] reset_delay(input cssc_pkg::cssc_src_t k, input logic lo, input logic [1:0] startup_time_select);
    logic [1:0] d;
    d = cssc_pkg::DLY_NONE;
    if (k == cssc_pkg::SRC_XTAL) begin
      case ({lo, startup_time_select})
        3'h0, 3'h3, 3'h6: d = cssc_pkg::DLY_SHORT;
        3'h1, 3'h4, 3'h7: d = cssc_pkg::DLY_LONG;
        default: d = cssc_pkg::DLY_NONE;
      endcase
    end else if (k == cssc_pkg::SRC_LFXT) begin
      d = (startup_time_select == 2'h0) ? cssc_pkg::DLY_SHORT : cssc_pkg::DLY_LONG;
    end else if (k == cssc_pkg::SRC_ERC) begin
      case (startup_time_select)
        2'h0: d = cssc_pkg::DLY_NONE;
        2'h2: d = cssc_pkg::DLY_LONG;
        default: d = cssc_pkg::DLY_SHORT;
      endcase
    end else begin
      case (startup_time_select)
        2'h1: d = cssc_pkg::DLY_SHORT;
        2'h2: d = cssc_pkg::DLY_LONG;
        default: d = cssc_pkg::DLY_NONE;
      endcase
    end
    return d;
  endfunction

  // ==========================================
  // state
  typedef struct packed {
    cssc_pkg::cssc_state_t st;
    logic [16:0] wdt_cnt;
    logic [16:0] src_cnt;
    logic [3:0] src_sel;
    logic [1:0] sut_sel;
    logic opt;
    logic [2:0] slp;
    logic core_en;
    logic io_en;
    logic asy_en;
    logic adc_en;
    logic err;
  } cssc_state_s_t;

  cssc_state_s_t s_r;
  cssc_state_s_t s_nxt;
  cssc_pkg::cssc_src_t kind;
  logic [16:0] wake_cnt;
  logic [1:0] dly_cls;
  logic [16:0] dly_cycles;

  // fuses latched by a clocked process after reset release, never by the reset itself
  always_comb begin
    kind = decode_src(s_r.src_sel);
    wake_cnt = wake_count(kind, s_r.src_sel[0], s_r.sut_sel);
    dly_cls = reset_delay(kind, s_r.src_sel[0], s_r.sut_sel);
    case (dly_cls)
      cssc_pkg::DLY_SHORT: dly_cycles = 17'(WDT_SHORT);
      cssc_pkg::DLY_LONG: dly_cycles = 17'(WDT_LONG);
      default: dly_cycles = 17'h00000;
    endcase
  end

  // ==========================================
  // sequencing
  always_comb begin
    s_nxt = s_r;
    s_nxt.core_en = 1'h0;
    s_nxt.io_en = 1'h0;
    s_nxt.asy_en = 1'h0;
    s_nxt.adc_en = 1'h0;
    case (s_r.st)
      cssc_pkg::ST_RESET_DLY: begin
        // fuses track inputs until reset timing ends; reset values are the delivered defaults
        if (FUSES_VALID) begin
          s_nxt.src_sel = CLOCK_SOURCE_SELECT;
          s_nxt.sut_sel = STARTUP_TIME_SELECT;
          s_nxt.opt = OSCILLATOR_OPTION;
        end
        if (s_r.err) begin
          s_nxt.st = cssc_pkg::ST_FAULT;
        end else if (s_r.wdt_cnt >= dly_cycles) begin
          s_nxt.st = cssc_pkg::ST_SRC_START;
          s_nxt.src_cnt = 17'h00000;
        end else if (WDT_TICK) begin
          s_nxt.wdt_cnt = s_r.wdt_cnt + 17'h00001;
        end
        s_nxt.err = wake_cnt[16];
      end
      cssc_pkg::ST_SRC_START: begin
        // source cycles counted on every edge; domains still gated
        if (s_r.src_cnt >= {1'h0, wake_cnt[15:0]}) begin
          s_nxt.st = cssc_pkg::ST_RUN;
          s_nxt.core_en = 1'h1;
          s_nxt.io_en = 1'h1;
          s_nxt.asy_en = 1'h1;
          s_nxt.adc_en = 1'h1;
        end else begin
          s_nxt.src_cnt = s_r.src_cnt + 17'h00001;
        end
      end
      cssc_pkg::ST_RUN: begin
        s_nxt.core_en = 1'h1;
        s_nxt.io_en = 1'h1;
        s_nxt.asy_en = 1'h1;
        s_nxt.adc_en = 1'h1;
        if (SLEEP_REQ) begin
          s_nxt.st = cssc_pkg::ST_SLEEP;
          s_nxt.slp = SLEEP_MODE;
          s_nxt.core_en = 1'h0;
          s_nxt.io_en = (SLEEP_MODE == cssc_pkg::SLP_IDLE);
          s_nxt.adc_en = (SLEEP_MODE == cssc_pkg::SLP_IDLE) || (SLEEP_MODE == cssc_pkg::SLP_ADC_NR);
          s_nxt.asy_en = (SLEEP_MODE != cssc_pkg::SLP_PDOWN) && (SLEEP_MODE != cssc_pkg::SLP_STANDBY);
        end
      end
      cssc_pkg::ST_SLEEP: begin
        s_nxt.io_en = s_r.io_en;
        s_nxt.adc_en = s_r.adc_en;
        s_nxt.asy_en = s_r.asy_en;
        if (WAKE_REQ) begin
          // oscillator stopped only in power-down and power-save; re-time its start-up
          if (s_r.slp == cssc_pkg::SLP_PDOWN || s_r.slp == cssc_pkg::SLP_PSAVE) begin
            s_nxt.st = cssc_pkg::ST_SRC_START;
            s_nxt.src_cnt = 17'h00000;
            s_nxt.io_en = 1'h0;
            s_nxt.adc_en = 1'h0;
          end else begin
            s_nxt.st = cssc_pkg::ST_RUN;
            s_nxt.core_en = 1'h1;
            s_nxt.io_en = 1'h1;
            s_nxt.adc_en = 1'h1;
            s_nxt.asy_en = 1'h1;
          end
        end
      end
      cssc_pkg::ST_FAULT: begin
        // reserved start-up code: stay gated, since no safe count exists
        s_nxt.err = 1'h1;
      end
      default: begin
        s_nxt.st = cssc_pkg::ST_RESET_DLY;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      s_r.st <= cssc_pkg::ST_RESET_DLY;
      s_r.wdt_cnt <= 17'h00000;
      s_r.src_cnt <= 17'h00000;
      s_r.src_sel <= cssc_pkg::DEF_SRC_SEL;
      s_r.sut_sel <= cssc_pkg::DEF_SUT_SEL;
      s_r.opt <= ~cssc_pkg::FUSE_PROGRAMMED;
      s_r.slp <= cssc_pkg::SLP_IDLE;
      s_r.core_en <= 1'h0;
      s_r.io_en <= 1'h0;
      s_r.asy_en <= 1'h0;
      s_r.adc_en <= 1'h0;
      s_r.err <= 1'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // outputs
  assign CORE_CLOCK_EN = s_r.core_en;
  assign FLASH_CLOCK_EN = s_r.core_en;
  assign PERIPHERAL_CLOCK_EN = s_r.io_en;
  assign ASYNC_TIMER_CLOCK_EN = s_r.asy_en;
  assign CONVERTER_CLOCK_EN = s_r.adc_en;
  assign ASYNC_WAKE_LOGIC_EN = 1'h1;
  assign EXEC_READY = s_r.core_en;
  assign SOURCE_KIND = kind;
  assign XTAL_MODE = (kind == cssc_pkg::SRC_XTAL) ? 2'(s_r.src_sel[3:1] - cssc_pkg::XTAL_MODE_LO) : 2'h0;
  assign FULL_SWING = (s_r.opt == cssc_pkg::FUSE_PROGRAMMED);
  assign CONFIG_ERROR = s_r.err;
endmodule

// File: bench/cssc_top_asserts.sv
// port checker for the clock source start-up block
// assumes bind to cssc_top; fuse inputs held still outside reset
`timescale 1ns/1ps
module cssc_asserts (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [3:0] CLOCK_SOURCE_SELECT,
  input wire logic SLEEP_REQ,
  input wire logic [2:0] SLEEP_MODE,
  input wire logic CORE_CLOCK_EN,
  input wire logic FLASH_CLOCK_EN,
  input wire logic PERIPHERAL_CLOCK_EN,
  input wire logic ASYNC_TIMER_CLOCK_EN,
  input wire logic CONVERTER_CLOCK_EN,
  input wire logic EXEC_READY,
  input wire logic [4:0] SOURCE_KIND,
  input wire logic CONFIG_ERROR
);
  // ==========================================
  // expected kind, kept apart from the design's decoder
  function automatic logic [4:0] kind_of(input logic [3:0] s);
    if (s >= 4'hA) return 5'h01;
    if (s == 4'h9) return 5'h02;
    if (s >= 4'h5) return 5'h04;
    if (s >= 4'h1) return 5'h08;
    return 5'h10;
  endfunction
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ==========================================
  // assertions
  chk_flash_core: assert property (FLASH_CLOCK_EN == CORE_CLOCK_EN)
    else $error("flash enable differs from core enable");
  chk_exec_core: assert property (EXEC_READY == CORE_CLOCK_EN)
    else $error("execution runs without core clock");
  chk_kind_decode: assert property ($rose(CORE_CLOCK_EN) |-> SOURCE_KIND == kind_of(CLOCK_SOURCE_SELECT))
    else $error("source kind wrong at start");
  chk_gate_start: assert property ($fell(SYS_RST) |->
    !(CORE_CLOCK_EN | PERIPHERAL_CLOCK_EN | ASYNC_TIMER_CLOCK_EN | CONVERTER_CLOCK_EN) [*7])
    else $error("domain enabled before start-up count");
  chk_idle_gate: assert property (SLEEP_REQ && CORE_CLOCK_EN && SLEEP_MODE == cssc_pkg::SLP_IDLE |=>
    !CORE_CLOCK_EN && PERIPHERAL_CLOCK_EN && CONVERTER_CLOCK_EN)
    else $error("idle sleep gating wrong");
  chk_psave_timer: assert property (SLEEP_REQ && CORE_CLOCK_EN && SLEEP_MODE == cssc_pkg::SLP_PSAVE |=>
    ASYNC_TIMER_CLOCK_EN && !PERIPHERAL_CLOCK_EN && !CONVERTER_CLOCK_EN)
    else $error("async timer stopped in power-save");
  chk_adc_domain: assert property (SLEEP_REQ && CORE_CLOCK_EN && SLEEP_MODE == cssc_pkg::SLP_ADC_NR |=>
    CONVERTER_CLOCK_EN && !PERIPHERAL_CLOCK_EN && !CORE_CLOCK_EN)
    else $error("converter gating wrong in noise reduction");
  chk_fault_gate: assert property (CONFIG_ERROR |-> !CORE_CLOCK_EN && !PERIPHERAL_CLOCK_EN)
    else $error("clocks run with reserved start-up code");
  cover property ($rose(CORE_CLOCK_EN));
  cover property (SLEEP_REQ && CORE_CLOCK_EN && SLEEP_MODE == cssc_pkg::SLP_PDOWN);
  cover property (CONFIG_ERROR);
endmodule

// File: bench/cssc_wdt_osc.sv
// watchdog oscillator stand-in: one-cycle tick every DIV source cycles
// assumes the source clock runs throughout; tick changes off the sampling edge
`timescale 1ns/1ps
module cssc_wdt_osc #(
  parameter int DIV = 4
) (
  input wire logic CLOCK,
  output logic TICK
);
  int cnt = 0;
  initial TICK = 1'b0;
  always @(negedge CLOCK) begin
    cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
    TICK <= (cnt == DIV - 1);
  end
endmodule

// File: bench/tb_clock_source_startup_control.sv
// testbench for the clock source start-up block
// assumes watchdog limits cut to 8/16 ticks and a tick every TP cycles
`timescale 1ns/1ps
module tb_clock_source_startup_control;
  localparam int TP = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fv = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [1:0] startup_time_select = 2'h0;
  logic opt = 1'b1;
  logic slp = 1'b0;
  logic [2:0] mode = 3'h0;
  logic wake = 1'b0;
  logic tick, core, flash, peri, asy, conv, awk, exr, swing, cerr;
  logic [4:0] kind;
  logic [1:0] xm;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  cssc_top #(.WDT_SHORT(8), .WDT_LONG(16)) dut (
    .CLOCK(clk), .SYS_RST(rst), .FUSES_VALID(fv), .CLOCK_SOURCE_SELECT(sel),
    .STARTUP_TIME_SELECT(startup_time_select), .OSCILLATOR_OPTION(opt), .WDT_TICK(tick),
    .SLEEP_REQ(slp), .SLEEP_MODE(mode), .WAKE_REQ(wake), .CORE_CLOCK_EN(core),
    .FLASH_CLOCK_EN(flash), .PERIPHERAL_CLOCK_EN(peri), .ASYNC_TIMER_CLOCK_EN(asy),
    .CONVERTER_CLOCK_EN(conv), .ASYNC_WAKE_LOGIC_EN(awk), .EXEC_READY(exr),
    .SOURCE_KIND(kind), .XTAL_MODE(xm), .FULL_SWING(swing), .CONFIG_ERROR(cerr)
  );
  cssc_wdt_osc #(.DIV(TP)) osc (.CLOCK(clk), .TICK(tick));
  // ==========================================
  // shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset(input logic [3:0] s, input logic [1:0] u, input logic o);
    @(negedge clk);
    rst = 1'b1;
    sel = s;
    startup_time_select = u;
    opt = o;
    repeat (10) @(negedge clk);
    fv = 1'b1;
    rst = 1'b0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_start(input logic [3:0] s, input logic [1:0] u, input logic o, input int n, input int d,
                         input logic [4:0] k);
    int c;
    int lo;
    do_reset(s, u, o);
    c = 0;
    while (core !== 1'b1 && c < 40000) begin
      @(negedge clk);
      c++;
    end
    lo = d * TP + n - TP;
    check("startup window", 32'(c >= lo && c <= d * TP + n + 10), 32'h1);
    check("source kind", 32'(kind), 32'(k));
    check("full swing", 32'(swing), 32'(!o));
    if (k == 5'h01) check("xtal mode", 32'(xm), (s[3:1] == 3'h5) ? 32'h0 : ((s[3:1] == 3'h6) ? 32'h1 : 32'h2));
  endtask
  task automatic t_sleep(input logic [2:0] m, input logic [3:0] e, input int wmin, input int wmax);
    int c;
    @(negedge clk);
    slp = 1'b1;
    mode = m;
    @(negedge clk);
    slp = 1'b0;
    check("sleep enables", 32'({core, peri, asy, conv}), 32'(e));
    repeat (3) @(negedge clk);
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    c = 1;
    while (core !== 1'b1 && c < 100) begin
      @(negedge clk);
      c++;
    end
    check("wake delay", 32'(c >= wmin && c <= wmax), 32'h1);
    check("run enables", 32'({core, peri, asy, conv}), 32'hF);
  endtask
  task automatic t_fault();
    do_reset(4'h9, 2'h3, 1'b1);
    repeat (40) @(negedge clk);
    check("config error", 32'(cerr), 32'h1);
    check("gated on fault", 32'({core, peri, asy, conv}), 32'h0);
  endtask
  // ==========================================
  // main sequence and hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    check("default kind", 32'(kind), 32'h08);
    t_start(4'h1, 2'h2, 1'b1, 6, 16, 5'h08);
    check("async wake logic", 32'(awk), 32'h1);
    t_sleep(3'h0, 4'h7, 1, 1);
    t_sleep(3'h1, 4'h3, 1, 1);
    t_sleep(3'h2, 4'h0, 7, 9);
    t_sleep(3'h3, 4'h2, 7, 9);
    t_sleep(3'h6, 4'h0, 1, 1);
    t_sleep(3'h7, 4'h2, 1, 1);
    t_start(4'hA, 2'h0, 1'b1, 258, 8, 5'h01);
    t_start(4'hC, 2'h1, 1'b0, 258, 16, 5'h01);
    t_start(4'hE, 2'h2, 1'b1, 1024, 0, 5'h01);
    t_start(4'hA, 2'h3, 1'b0, 1024, 8, 5'h01);
    t_start(4'hB, 2'h0, 1'b1, 1024, 16, 5'h01);
    t_start(4'hD, 2'h1, 1'b0, 16384, 0, 5'h01);
    t_start(4'h9, 2'h2, 1'b0, 32768, 16, 5'h02);
    t_start(4'h5, 2'h3, 1'b1, 6, 8, 5'h04);
    t_start(4'h0, 2'h0, 1'b0, 6, 0, 5'h10);
    t_fault();
    stop_test();
  end
endmodule
bind cssc_top cssc_asserts chk (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT), .SLEEP_REQ(SLEEP_REQ),
  .SLEEP_MODE(SLEEP_MODE), .CORE_CLOCK_EN(CORE_CLOCK_EN), .FLASH_CLOCK_EN(FLASH_CLOCK_EN),
  .PERIPHERAL_CLOCK_EN(PERIPHERAL_CLOCK_EN), .ASYNC_TIMER_CLOCK_EN(ASYNC_TIMER_CLOCK_EN),
  .CONVERTER_CLOCK_EN(CONVERTER_CLOCK_EN), .EXEC_READY(EXEC_READY), .SOURCE_KIND(SOURCE_KIND),
  .CONFIG_ERROR(CONFIG_ERROR)
);
